// File: core/gauge_pkg.sv
package gauge_pkg;
  localparam int DATA_W = 16;
  localparam int PADDR_W = 10;
  localparam logic [7:0] IDX_TERM = 8'h1e;
  localparam logic [7:0] IDX_REV = 8'h21;
  localparam logic [7:0] IDX_LEARN = 8'h28;
  localparam logic [PADDR_W-1:0] ADDR_TERM = {IDX_TERM, 2'h0};
  localparam logic [PADDR_W-1:0] ADDR_REV = {IDX_REV, 2'h0};
  localparam logic [PADDR_W-1:0] ADDR_LEARN = {IDX_LEARN, 2'h0};
  localparam logic [15:0] TERM_RESET = 16'h0640;
  localparam logic [15:0] LEARN_RESET = 16'h4486;
  localparam int LS_LSB = 4;
  localparam int LS_MSB = 6;
  localparam logic [2:0] LS_INIT = 3'h0;
  localparam logic [2:0] LS_MID = 3'h3;
  localparam logic [2:0] LS_FINAL = 3'h7;
  localparam logic [2:0] LS_IGN_LO = 3'h1;
  localparam logic [2:0] LS_IGN_HI = 3'h6;
  localparam logic [15:0] LS_MASK = 16'h0070;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TERM_QUAL_NS = 1000;
  localparam int TERM_QUAL_CYC = (TERM_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_ONE,
    CYC_TWO
  } cycle_cnt_t;
endpackage

// File: core/learn_stage_ctrl.sv
`timescale 1ns/10ps
module learn_stage_ctrl
  import gauge_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic host_wr,
  input wire logic [2:0] host_stage,
  input wire logic cycle_done,
  output logic [2:0] stage
);
  typedef struct packed {
    logic [2:0] stage;
    cycle_cnt_t cycles;
  } ls_state_t;

  ls_state_t state_r;
  ls_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (host_wr && host_stage == LS_FINAL) begin
      state_nxt.stage = LS_FINAL;
      state_nxt.cycles = CYC_TWO;
    end else if (host_wr && host_stage == LS_INIT) begin
      state_nxt.stage = LS_INIT;
      state_nxt.cycles = CYC_NONE;
    end else if (cycle_done) begin
      case (state_r.cycles)
        CYC_NONE: begin
          state_nxt.stage = LS_MID;
          state_nxt.cycles = CYC_ONE;
        end
        CYC_ONE: begin
          state_nxt.stage = LS_FINAL;
          state_nxt.cycles = CYC_TWO;
        end
        CYC_TWO: begin
          state_nxt.stage = LS_FINAL;
        end
        default: begin
          state_nxt.stage = LS_FINAL;
          state_nxt.cycles = CYC_TWO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '{stage: LS_INIT, cycles: CYC_NONE};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign stage = state_r.stage;
endmodule

// File: core/gauge_term_learn_regs.sv
// Behaviour
// - Termination current register, 16 bits read/write, resets to 0x0640.
// - Termination detected when charge current stays at or below programmed value.
// - Revision register is readable so software can identify the part.
// - Adaptation register bits 6:4 hold the three-bit learn stage.
// - Learn stage is zero after reset; voltage estimate dominates.
// - Learn stage advances itself to 7 over two full battery cycles.
// - Software writing 7 moves the learn stage straight to final.
// - Software writes of learn stage 1 through 6 are ignored.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module gauge_term_learn_regs
  import gauge_pkg::*;
#(
  parameter logic [15:0] REV_ID = 16'h5a01,
  parameter int QUAL_CYC = TERM_QUAL_CYC,
  parameter int QUAL_W = 16
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic charging,
  input wire logic signed [15:0] batt_current,
  input wire logic full_cycle_done,
  output logic [15:0] term_current,
  output logic term_detected,
  output logic [2:0] learn_stage
);
  // REV_ID default is an arbitrary neutral value

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] term;
    logic [15:0] cfg;
    logic [QUAL_W-1:0] qual_cnt;
    logic term_det;
  } regs_state_t;

  regs_state_t state_r;
  regs_state_t state_nxt;

  logic access;
  logic wr_done;
  logic rd_take;
  logic hit_term;
  logic hit_rev;
  logic hit_learn;
  logic mapped;
  logic below_term;
  logic learn_wr;
  logic [2:0] stage;
  logic [15:0] wr_half;
  logic [15:0] wr_mask;

  localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_CYC - 1);

  assign access = psel && penable;
  assign wr_done = access && state_r.pready && pwrite;
  assign rd_take = access && !state_r.pready;
  assign hit_term = paddr == ADDR_TERM;
  assign hit_rev = paddr == ADDR_REV;
  assign hit_learn = paddr == ADDR_LEARN;
  assign mapped = hit_term || hit_rev || hit_learn;
  assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_half = pwdata[15:0];
  assign learn_wr = wr_done && hit_learn && pstrb[0];

  assign below_term = !batt_current[15] && (16'(batt_current) <= state_r.term);

  always_comb begin
    state_nxt = state_r;
    state_nxt.pready = 1'b0;
    // One wait state: answer is registered on the same edge that raises pready
    if (rd_take) begin
      state_nxt.pready = 1'b1;
      state_nxt.pslverr = !mapped || (pwrite && hit_rev);
      state_nxt.prdata = RDATA_IDLE;
      if (!pwrite) begin
        if (hit_term) begin
          state_nxt.prdata = {16'h0000, state_r.term};
        end else if (hit_rev) begin
          state_nxt.prdata = {16'h0000, REV_ID};
        end else if (hit_learn) begin
          state_nxt.prdata = {16'h0000, state_r.cfg[15:LS_MSB+1], stage,
                              state_r.cfg[LS_LSB-1:0]};
        end
      end
    end
    if (wr_done && hit_term) begin
      state_nxt.term = (state_r.term & ~wr_mask) | (wr_half & wr_mask);
    end
    if (wr_done && hit_learn) begin
      state_nxt.cfg = (state_r.cfg & ~(wr_mask & ~LS_MASK)) | (wr_half & wr_mask & ~LS_MASK);
    end
    if (!charging) begin
      state_nxt.qual_cnt = '0;
      state_nxt.term_det = 1'b0;
    end else if (!below_term) begin
      state_nxt.qual_cnt = '0;
    end else if (state_r.qual_cnt == QUAL_LAST) begin
      state_nxt.term_det = 1'b1;
    end else begin
      state_nxt.qual_cnt = state_r.qual_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: RDATA_IDLE, term: TERM_RESET,
                   cfg: LEARN_RESET, qual_cnt: '0, term_det: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  learn_stage_ctrl u_learn (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .host_wr(learn_wr),
    .host_stage(wr_half[LS_MSB:LS_LSB]),
    .cycle_done(full_cycle_done),
    .stage(stage)
  );

  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign term_current = state_r.term;
  assign term_detected = state_r.term_det;
  assign learn_stage = stage;

  logic [QUAL_W-1:0] det_age;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      det_age <= '0;
    end else if (!charging || !below_term) begin
      det_age <= '0;
    end else if (det_age != QUAL_LAST) begin
      det_age <= det_age + 1'b1;
    end
  end

  a_pready_one_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");

  a_pready_single: assert property (@(posedge sys_clk) disable iff (!rstn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_term_write_takes: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && pready && pwrite && paddr == ADDR_TERM && pstrb[1:0] == 2'b11
    |=> term_current == $past(pwdata[15:0]))
    else $error("termination write not stored");

  a_term_hold_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(psel && penable && pready && pwrite && paddr == ADDR_TERM)
    |=> $stable(term_current))
    else $error("termination register changed without write");

  a_term_detect_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(term_detected) |-> $past(charging) && $past(det_age) == QUAL_LAST)
    else $error("termination flagged without qualified low current");

  a_term_drop_charge: assert property (@(posedge sys_clk) disable iff (!rstn)
    !charging |=> !term_detected)
    else $error("termination flag kept while not charging");

  a_rev_read_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && pready && !pwrite && paddr == ADDR_REV
    |-> prdata == {16'h0000, REV_ID} && !pslverr)
    else $error("revision readback wrong");

  a_learn_read_map: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && pready && !pwrite && paddr == ADDR_LEARN
    |-> prdata[LS_MSB:LS_LSB] == $past(learn_stage) && prdata[31:16] == 16'h0000)
    else $error("learn stage not in bits 6:4");

  a_stage_leave_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(learn_stage) == LS_INIT && learn_stage != LS_INIT
    |-> $past(full_cycle_done) || $past(learn_wr))
    else $error("learn stage left zero without cause");

  a_stage_two_cycles: assert property (@(posedge sys_clk) disable iff (!rstn)
    learn_stage == LS_MID && full_cycle_done && !learn_wr |=> learn_stage == LS_FINAL)
    else $error("second cycle did not reach final stage");

  a_host_final_jump: assert property (@(posedge sys_clk) disable iff (!rstn)
    learn_wr && pwdata[LS_MSB:LS_LSB] == LS_FINAL |=> learn_stage == LS_FINAL [*2])
    else $error("write of 7 did not reach final stage");

  a_ignore_mid_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    learn_wr && pwdata[LS_MSB:LS_LSB] >= LS_IGN_LO && pwdata[LS_MSB:LS_LSB] <= LS_IGN_HI
    && !full_cycle_done |=> $stable(learn_stage))
    else $error("ignored stage value changed learn stage");

  a_other_bits_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && pready && pwrite && paddr == ADDR_LEARN && pstrb[1:0] == 2'b11
    |=> (state_r.cfg & ~LS_MASK) == ($past(pwdata[15:0]) & ~LS_MASK))
    else $error("other adaptation bits not stored");

  a_unmapped_error: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && penable && pready && paddr != ADDR_TERM && paddr != ADDR_REV
    && paddr != ADDR_LEARN |-> pslverr && prdata == RDATA_IDLE)
    else $error("unmapped access not flagged");
endmodule

// File: tb/apb_host.sv
`timescale 1ns/10ps
module apb_host
  import gauge_pkg::*;
(
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [PADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h3;
  end
  function automatic logic [15:0] adapt_word(input logic [2:0] s);
    return 16'h4486 | {9'h0, s, 4'h0};
  endfunction
  // Entered just after a rising edge; one idle edge follows so psel never toggles twice
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // No local timeout: pready ends this wait, or the bench timeout if pready never rises
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench
  import gauge_pkg::*;
;
  localparam int QC = 4;
  // Arbitrary revision value
  localparam logic [15:0] REV_VAL = 16'h3c5a;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic charging, full_cycle_done, term_detected;
  logic signed [15:0] batt_current;
  logic [15:0] term_current, rd, v;
  logic [2:0] learn_stage, es;
  logic [2:0] wr_seq [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h0};
  int num_errors, checks, cycles;
  apb_host i_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  gauge_term_learn_regs #(.REV_ID(REV_VAL), .QUAL_CYC(QC), .QUAL_W(16)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .charging(charging), .batt_current(batt_current),
    .full_cycle_done(full_cycle_done), .term_current(term_current),
    .term_detected(term_detected), .learn_stage(learn_stage));
  always #2.5 sys_clk = ~sys_clk;
  function automatic logic [15:0] adapt_exp(input logic [2:0] s);
    return (16'h4486 & ~LS_MASK) | {9'h0, s, 4'h0};
  endfunction
  function automatic logic [2:0] next_stage(input logic [2:0] cur, input logic [2:0] w);
    return (w == 3'h7) ? 3'h7 : (w == 3'h0) ? 3'h0 : cur;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard; the whole run needs well under this
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    charging = 1'b0;
    batt_current = '0;
    full_cycle_done = 1'b0;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(85672));
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    i_host.xfer(1'b0, ADDR_TERM, 16'h0, rd, err);
    chk(rd, TERM_RESET); // reset value
    chk(term_current, TERM_RESET); // port copy
    i_host.xfer(1'b0, ADDR_LEARN, 16'h0, rd, err);
    chk(rd, adapt_exp(LS_INIT)); // reset image
    chk(learn_stage, 3'h0); // stage zero
    $display("test reset done");
    i_host.xfer(1'b0, ADDR_REV, 16'h0, rd, err);
    chk(rd, REV_VAL); // readable
    chk(err, 1'b0); // no error
    i_host.xfer(1'b1, ADDR_REV, 16'hffff, rd, err);
    chk(err, 1'b1); // read only
    i_host.xfer(1'b0, ADDR_REV, 16'h0, rd, err);
    chk(rd, REV_VAL); // unchanged
    i_host.xfer(1'b0, 10'h3fc, 16'h0, rd, err);
    chk({err, rd}, 17'h10000); // unmapped refused
    $display("test revision done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
      i_host.xfer(1'b1, ADDR_TERM, v, rd, err);
      i_host.xfer(1'b0, ADDR_TERM, 16'h0, rd, err);
      chk(rd, v); // read back
      chk(term_current, v); // port copy
    end
    $display("test term register done");
    es = 3'h0;
    for (int i = 0; i < 9; i++) begin
      i_host.xfer(1'b1, ADDR_LEARN, i_host.adapt_word(wr_seq[i]), rd, err);
      es = next_stage(es, wr_seq[i]);
      @(posedge sys_clk);
      chk(learn_stage, es); // stage write
      i_host.xfer(1'b0, ADDR_LEARN, 16'h0, rd, err);
      chk(rd, adapt_exp(es)); // field readback
    end
    $display("test stage writes done");
    for (int k = 0; k < 3; k++) begin
      full_cycle_done <= 1'b1;
      @(posedge sys_clk);
      full_cycle_done <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(learn_stage, (k == 0) ? 3'h3 : 3'h7); // self advance
    end
    $display("test learning done");
    v = 16'h0100 + 16'($urandom & 32'h0fff);
    i_host.xfer(1'b1, ADDR_TERM, v, rd, err);
    charging <= 1'b1;
    batt_current <= v + 16'h1;
    repeat (QC + 6) @(posedge sys_clk);
    chk(term_detected, 1'b0); // above band
    batt_current <= 16'($urandom % (32'(v) + 1));
    repeat (QC + 6) @(posedge sys_clk);
    chk(term_detected, 1'b1); // in band
    charging <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(term_detected, 1'b0); // cleared
    $display("test termination done");
    conclude();
  end
endmodule
